/* File: rtl/tbam_cfg.svh */
// Purpose : constants for the ten-bit multi-address target matcher
// Assumes : included by its bare name
// Notes   : definitions only
`ifndef TBAM_CFG_SVH
`define TBAM_CFG_SVH
`define TBAM_NUM_ADDR      4
`define TBAM_HDR_PREFIX    5'h1E
`define TBAM_HDR_PFX_MSB   7
`define TBAM_HDR_PFX_LSB   3
`define TBAM_HDR_HI_MSB    2
`define TBAM_HDR_HI_LSB    1
`define TBAM_HDR_RW_BIT    0
`define TBAM_ADDR_HI_MSB   9
`define TBAM_ADDR_HI_LSB   8
`define TBAM_ADDR_LO_MSB   7
`define TBAM_ADDR_LO_LSB   0
`endif

/* File: rtl/tbam_pkg.sv */
// Purpose : types for the ten-bit multi-address target matcher
// Assumes : nothing
// Notes   : byte stream carrier from the shift logic
package tbam_pkg;
   typedef struct packed {
      logic       start;   // start or repeated start seen
      logic       stop;    // stop seen
      logic       valid;   // one received byte complete
      logic [7:0] data;
   } tbam_byte_t;

   typedef struct packed {
      logic       ack;     // drive ack for the byte just offered
      logic       data_en; // target is receiving data
      logic [1:0] idx;     // address index that matched
   } tbam_resp_t;

   typedef enum logic [1:0] {
      TBAM_IDLE = 2'b00,
      TBAM_HDR2 = 2'b01,
      TBAM_DATA = 2'b11,
      TBAM_SKIP = 2'b10
   } tbam_state_t;
endpackage

/* File: rtl/tbam_match.sv */
// Purpose : address recognition for a target answering four 10-bit addresses
// Assumes : bytes, start and stop come from logic on sys_clk, one-cycle pulses
// Notes   : ack is a one-cycle pulse in the cycle after the byte's valid
//           data_en stays high from the full match until start or stop
//           outputs stay low for two cycles after reset release
`timescale 1ns/1ps
`include "tbam_cfg.svh"

// Notes on behaviour
// RQ1: hold four 10-bit own addresses, compare headers against all of them
// RQ2: a 10-bit address arrives as header byte then second byte
// RQ3: header byte is 11110, two upper address bits, then read/write
// RQ4: second byte carries the low eight address bits
// RQ5: ack header when its upper bits equal any enabled own address
// RQ6: ack second byte only on full 10-bit match of one address
// RQ7: upper bits of one address and low bits of another never match
// RQ8: accept data only after full match, else ignore following bytes
// RQ9: per-address header flags qualify second byte, cleared at every start
module tbam_match #(
   parameter int NUM_ADDR = `TBAM_NUM_ADDR
) (
   input  wire logic                    sys_clk,
   input  wire logic                    nrst,
   input  wire logic                    multi_en,
   input  wire logic [NUM_ADDR-1:0]     addr_en,
   input  wire logic [NUM_ADDR*10-1:0]  own_addr,
   input  wire tbam_pkg::tbam_byte_t    rx_in,
   output tbam_pkg::tbam_resp_t         resp,
   output logic                         rx_dir_read
);
   import tbam_pkg::*;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_s1_q;
   logic rst_n_q;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // comparison
   // ----------------------------------------------------------------
   // own address fields of one slot
   function automatic logic [1:0] addr_hi(input logic [NUM_ADDR*10-1:0] v, input int i);
      logic [9:0] a;
      a       = v[i*10 +: 10];
      addr_hi = a[`TBAM_ADDR_HI_MSB:`TBAM_ADDR_HI_LSB];
   endfunction

   function automatic logic [7:0] addr_lo(input logic [NUM_ADDR*10-1:0] v, input int i);
      logic [9:0] a;
      a       = v[i*10 +: 10];
      addr_lo = a[`TBAM_ADDR_LO_MSB:`TBAM_ADDR_LO_LSB];
   endfunction

   // start and stop both end whatever sequence was under way
   function automatic logic frame_edge(input tbam_byte_t b);
      frame_edge = b.start || b.stop;
   endfunction

   // lowest slot wins, so two slots holding one address still give one index
   function automatic logic [1:0] lowest_hit(input logic [NUM_ADDR-1:0] hits);
      lowest_hit = 2'h0;
      for (int i = NUM_ADDR - 1; i >= 0; i--) begin
         if (hits[i])
            lowest_hit = 2'(i);
      end
   endfunction

   tbam_state_t         state_q;
   tbam_state_t         state_d;
   logic [NUM_ADDR-1:0] slot_on;
   logic [NUM_ADDR-1:0] hi_hit_q;
   logic [NUM_ADDR-1:0] hi_hit_d;
   logic [NUM_ADDR-1:0] full_hit;
   logic                any_hi;
   logic                any_full;
   logic                is_hdr;
   logic                seq_end;
   logic                byte_in;
   logic [1:0]          idx_d;
   logic                ack_q;
   logic                ack_d;
   logic                data_en_q;
   logic [1:0]          idx_q;
   logic                dir_q;

   assign seq_end = frame_edge(rx_in);
   // a byte that shares its cycle with start or stop belongs to no sequence
   assign byte_in = rx_in.valid && !seq_end;
   assign is_hdr  = rx_in.data[`TBAM_HDR_PFX_MSB:`TBAM_HDR_PFX_LSB] == `TBAM_HDR_PREFIX; // RQ3

   // only slot 0 takes part unless multiple-target mode is on
   always_comb begin
      slot_on = addr_en;
      if (!multi_en)
         slot_on = addr_en & NUM_ADDR'(1); // RQ1
   end

   always_comb begin
      hi_hit_d = '0;
      for (int i = 0; i < NUM_ADDR; i++) begin
         hi_hit_d[i] = slot_on[i] && is_hdr &&
            (rx_in.data[`TBAM_HDR_HI_MSB:`TBAM_HDR_HI_LSB] == addr_hi(own_addr, i)); // RQ1 RQ5
      end
   end

   // one flag per slot: a single shared flag would let the upper bits of one
   // slot pair with the low byte of another
   always_comb begin
      full_hit = '0;
      for (int i = 0; i < NUM_ADDR; i++) begin
         full_hit[i] = hi_hit_q[i] && (rx_in.data == addr_lo(own_addr, i)); // RQ4 RQ6 RQ7 RQ9
      end
   end

   assign any_hi   = |hi_hit_d;
   assign any_full = |full_hit;
   assign idx_d    = lowest_hit(full_hit);

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   // a header that misses every slot parks in skip until the next start or stop
   always_comb begin
      state_d = state_q;
      if (seq_end) begin
         state_d = TBAM_IDLE;
      end else if (byte_in) begin
         case (state_q)
            TBAM_IDLE: state_d = any_hi ? TBAM_HDR2 : TBAM_SKIP; // RQ2
            TBAM_HDR2: state_d = any_full ? TBAM_DATA : TBAM_SKIP; // RQ8
            TBAM_DATA: state_d = TBAM_DATA;
            TBAM_SKIP: state_d = TBAM_SKIP; // RQ8
            default:   state_d = TBAM_IDLE;
         endcase
      end
   end

   // gray codes along idle, second byte, data
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= TBAM_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hi_hit_q <= '0;
      end else if (seq_end) begin
         hi_hit_q <= '0; // RQ9
      end else if (byte_in && state_q == TBAM_IDLE) begin
         hi_hit_q <= hi_hit_d;
      end
   end

   // ----------------------------------------------------------------
   // response
   // ----------------------------------------------------------------
   // ack answers the byte of the previous cycle and stands for one cycle only
   always_comb begin
      ack_d = 1'b0;
      if (byte_in) begin
         case (state_q)
            TBAM_IDLE: ack_d = any_hi; // RQ5
            TBAM_HDR2: ack_d = any_full; // RQ6 RQ7
            TBAM_DATA: ack_d = 1'b1; // RQ8
            TBAM_SKIP: ack_d = 1'b0; // RQ8
            default:   ack_d = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   // data_en is a level; ack alone marks each accepted byte
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         data_en_q <= 1'b0;
      end else if (seq_end) begin
         data_en_q <= 1'b0;
      end else if (byte_in && state_q == TBAM_HDR2) begin
         data_en_q <= any_full; // RQ8
      end
   end

   // the index is kept after stop so the data side can still tell which slot hit
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         idx_q <= 2'h0;
      end else if (byte_in && state_q == TBAM_HDR2) begin
         idx_q <= idx_d; // RQ6
      end
   end

   // direction of the last header, matched or not
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         dir_q <= 1'b0;
      end else if (byte_in && state_q == TBAM_IDLE) begin
         dir_q <= rx_in.data[`TBAM_HDR_RW_BIT]; // RQ3
      end
   end

   assign resp        = '{ack: ack_q, data_en: data_en_q, idx: idx_q};
   assign rx_dir_read = dir_q;
endmodule // tbam_match

/* File: dv/tbam_ctl_model.sv */
// Purpose: bus controller that sends 10-bit address frames
// Assumes: byte pulses on sys_clk
// Notes: counts acks seen since the last start
`timescale 1ns/1ps
module tbam_ctl_model (
   input  wire logic                 sys_clk,
   output tbam_pkg::tbam_byte_t      rx,
   input  wire tbam_pkg::tbam_resp_t resp
);
   import tbam_pkg::*;
   logic [7:0] acks = 8'h00;
   initial rx = '0;
   always @(posedge sys_clk) acks <= rx.start ? 8'h00 : acks + {7'h00, resp.ack};
   // idle data is inverted so a stale byte never looks valid
   task automatic put(input logic s, input logic p, input logic v, input logic [7:0] d);
      @(posedge sys_clk);
      rx <= '{start: s, stop: p, valid: v, data: d};
   endtask
   // p low leaves the bus held, so the next frame opens with a repeated start
   task automatic frame_raw(input logic [7:0] h, input logic [7:0] l, input int n, input logic p);
      put(1'b1, 1'b0, 1'b0, ~rx.data);
      put(1'b0, 1'b0, 1'b1, h);
      put(1'b0, 1'b0, 1'b1, l);
      for (int i = 0; i < n; i++) put(1'b0, 1'b0, 1'b1, 8'hA5 ^ 8'(i));
      put(1'b0, p, 1'b0, ~rx.data);
      repeat (2) put(1'b0, 1'b0, 1'b0, ~rx.data);
   endtask
   task automatic frame(input logic [9:0] a, input logic rd, input int n);
      frame_raw({5'h1E, a[9:8], rd}, a[7:0], n, 1'b1);
   endtask
endmodule // tbam_ctl_model

/* File: dv/tbam_match_monitor.sv */
// Purpose: port checks of the address matcher
// Assumes: one clock, async active-low reset
// Notes: last two bytes rebuild the matched address
`timescale 1ns/1ps
module tbam_match_monitor #(parameter int NUM_ADDR = 4) (
   input wire logic                    sys_clk,
   input wire logic                    nrst,
   input wire logic                    multi_en,
   input wire logic [NUM_ADDR-1:0]     addr_en,
   input wire logic [NUM_ADDR*10-1:0]  own_addr,
   input wire tbam_pkg::tbam_byte_t    rx_in,
   input wire tbam_pkg::tbam_resp_t    resp,
   input wire logic                    rx_dir_read
);
   import tbam_pkg::*;
   logic [7:0] b0_q, b1_q;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) {b1_q, b0_q} <= 16'h0000;
      else if (rx_in.valid) {b1_q, b0_q} <= {b0_q, rx_in.data};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   chk_ack_after_valid: assert property (resp.ack |-> $past(rx_in.valid)) else $error("ack without byte");
   chk_data_after_ack: assert property ($rose(resp.data_en) |-> resp.ack) else $error("data_en no ack");
   chk_data_cleared: assert property (rx_in.start || rx_in.stop |=> !resp.data_en) else $error("data_en held");
   chk_start_no_ack: assert property (rx_in.start |=> !resp.ack) else $error("ack after start");
   chk_full_match: assert property ($rose(resp.data_en) |-> addr_en[resp.idx] &&
      {b1_q[7:1], b0_q} == {5'h1E, own_addr[resp.idx*10 +: 10]}) else $error("wrong match");
   chk_slot_zero: assert property ($rose(resp.data_en) && !multi_en |-> resp.idx == 2'h0) else $error("slot");
   chk_dir_bit: assert property ($rose(resp.data_en) |-> rx_dir_read == b1_q[0]) else $error("dir");
   chk_data_acked: assert property (resp.data_en && rx_in.valid && !rx_in.start && !rx_in.stop
      |=> resp.ack) else $error("data not acked");
endmodule // tbam_match_monitor
bind tbam_match tbam_match_monitor #(.NUM_ADDR(NUM_ADDR)) u_mon (.sys_clk, .nrst, .multi_en, .addr_en,
   .own_addr, .rx_in, .resp, .rx_dir_read);

/* File: dv/tbam_match_tb_top.sv */
// Purpose: self-checking bench of the address matcher
// Assumes: controller model drives the byte stream
// Notes: distinct upper bits per slot make idx unique
`timescale 1ns/1ps
module tbam_match_tb_top;
   import tbam_pkg::*;
   logic        sys_clk = 1'b0, nrst = 1'b0, multi_en = 1'b1, rx_dir_read;
   logic [3:0]  addr_en = 4'hF;
   logic [39:0] own_addr = {10'h355, 10'h2C3, 10'h1A5, 10'h0F3};
   tbam_byte_t  rx_in;
   tbam_resp_t  resp;
   int          bad_count = 0, n_compared = 0;
   always #2.5 sys_clk = ~sys_clk;
   tbam_match dut (.sys_clk, .nrst, .multi_en, .addr_en, .own_addr, .rx_in, .resp, .rx_dir_read);
   tbam_ctl_model ctl (.sys_clk, .rx(rx_in), .resp);
   task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic s_full_match;
      for (int i = 0; i < 4; i++) begin
         ctl.frame(own_addr[i*10 +: 10], i[0], 2);
         compare("acks", 8'h04, ctl.acks);
         compare("idx", 8'(i), {6'h00, resp.idx});
         compare("dir", {7'h00, i[0]}, {7'h00, rx_dir_read});
      end
   endtask
   // upper bits of slot 0 with low byte of slot 1: header only
   task automatic s_cross_slots;
      ctl.frame(10'h0A5, 1'b0, 2);
      compare("acks", 8'h01, ctl.acks);
   endtask
   task automatic s_slot_off;
      addr_en <= 4'h7;
      ctl.frame(10'h355, 1'b0, 1);
      compare("acks", 8'h00, ctl.acks);
      addr_en <= 4'hF;
   endtask
   task automatic s_single;
      multi_en <= 1'b0;
      ctl.frame(10'h1A5, 1'b0, 1);
      compare("acks", 8'h00, ctl.acks);
      ctl.frame(10'h0F3, 1'b1, 1);
      compare("acks", 8'h03, ctl.acks);
      multi_en <= 1'b1;
   endtask
   // slot 0 upper bits behind a wrong prefix: never acked
   task automatic s_no_prefix;
      ctl.frame_raw({5'h1C, 2'b00, 1'b0}, 8'hF3, 1, 1'b1);
      compare("acks", 8'h00, ctl.acks);
   endtask
   // full match to slot 1 held open, then a repeated start with slot 0 upper bits
   task automatic s_restart;
      ctl.frame_raw({5'h1E, 2'b01, 1'b0}, 8'hA5, 1, 1'b0);
      compare("acks", 8'h03, ctl.acks);
      compare("data_en", 8'h01, {7'h00, resp.data_en});
      ctl.frame_raw({5'h1E, 2'b00, 1'b0}, 8'hA5, 1, 1'b1);
      compare("acks", 8'h01, ctl.acks);
      compare("data_en", 8'h00, {7'h00, resp.data_en});
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      compare("resp_rst", 8'h00, {3'h0, rx_dir_read, resp});
      s_full_match();
      s_cross_slots();
      s_slot_off();
      s_single();
      s_no_prefix();
      s_restart();
      report_and_stop();
   end
   initial begin
      #20000;
      bad_count++;
      report_and_stop();
   end
endmodule // tbam_match_tb_top
